// File: bench/lgx_ext_cmd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checker of the command interpreter
module lgx_ext_cmd_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_ready,
  input wire logic       continuous_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting for the slave
  sequence s_access;
    ce && psel && penable && !pready;
  endsequence
  // carriage return handed over
  sequence s_cr_taken;
    ce && tx_valid && tx_ready && tx_byte == 8'h0d;
  endsequence
  // line feed handed over, answer complete
  sequence s_lf_taken;
    ce && tx_valid && tx_ready && tx_byte == 8'h0a;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_one_wait: assert property (s_access |=> pready)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property ((ce && pready) |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (
    (ce && psel && penable && !pready && paddr > 8'h24) |=> pready && pslverr)
    else $error("unmapped access without error");
  a_ok_mapped: assert property (
    (ce && psel && penable && !pready && paddr <= 8'h24 && paddr[1:0] == 2'b00)
    |=> !pslverr)
    else $error("mapped access flagged as error");
  a_busy_refuse: assert property (tx_valid |-> !rx_ready)
    else $error("chars accepted during answer");
  a_stall_hold: assert property (
    (ce && tx_valid && !tx_ready) |=> tx_valid && $stable(tx_byte))
    else $error("answer char dropped during stall");
  a_cr_lf: assert property (s_cr_taken |=> tx_valid && tx_byte == 8'h0a)
    else $error("line feed does not follow return");
  a_answer_end: assert property (s_lf_taken |=> !tx_valid && rx_ready)
    else $error("answer does not end after line feed");
  a_mode_answer: assert property (
    $changed(continuous_mode) |-> ##[0:2] tx_valid)
    else $error("mode changed without an answer");
  a_ce_freeze: assert property (
    !ce |=> $stable(tx_valid) && $stable(tx_byte) && $stable(continuous_mode))
    else $error("outputs move with clock enable low");
  a_reset_out: assert property (
    $rose(presetn) |-> rx_ready && !tx_valid && !pready && !continuous_mode)
    else $error("outputs not idle after reset");
  // main scenarios reached
  c_lf: cover property (s_lf_taken);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // lgx_ext_cmd_asserts

bind lgx_ext_cmd lgx_ext_cmd_asserts lgx_ext_cmd_asserts_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .continuous_mode(continuous_mode)
);
`default_nettype wire

// File: bench/lgx_ext_cmd_tb.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// bench of the command interpreter
module lgx_ext_cmd_tb;
  // command, register to read, its value, data 0, data 1, count char
  typedef struct {
    string       c;
    logic [7:0]  ra;
    logic [31:0] rv;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [7:0]  n;
  } lgx_row_t;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;  // clock enable, dropped once
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic        tx_ready;
  logic        continuous_mode;
  logic        slow    = 1'b0;  // recorder stalls answers
  logic [7:0]  ea      = 8'h30; // expected address char
  logic [31:0] r;
  logic        e;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  lgx_row_t    rows [17] = '{
    '{"0XT+10!",   8'h08, 32'h0a,   32'h0a,  32'h0, 8'h31},
    '{"0XT+900!",  8'h08, 32'h384,  32'h384, 32'h0, 8'h31},
    '{"0XT+901!",  8'h08, 32'h384,  32'h384, 32'h0, 8'h31},
    '{"0XT!",      8'h08, 32'h384,  32'h384, 32'h0, 8'h31},
    '{"1XT+5!",    8'h08, 32'h384,  32'h384, 32'h0, 8'h00},
    '{"0XOM+1!",   8'h04, 32'h1201, 32'h1,   32'h0, 8'h31},
    '{"0XOM+2!",   8'h04, 32'h1201, 32'h1,   32'h0, 8'h31},
    '{"0XOM!",     8'h04, 32'h1201, 32'h1,   32'h0, 8'h31},
    '{"0XOM+0!",   8'h04, 32'h1200, 32'h0,   32'h0, 8'h31},
    '{"0XUP+1+3!", 8'h04, 32'h2310, 32'h1,   32'h3, 8'h32},
    '{"0XUP+9!",   8'h04, 32'h2390, 32'h9,   32'h3, 8'h32},
    '{"0XUP+7+8!", 8'h04, 32'h2390, 32'h9,   32'h3, 8'h32},
    '{"0XS+3!",    8'h0c, 32'hfa,   32'hfa,  32'h0, 8'h31},
    '{"0XS!",      8'h0c, 32'hfa,   32'hfa,  32'h0, 8'h31},
    '{"0XS2+7.87!", 8'h10, 32'h2af, 32'h2af, 32'h0, 8'h31},
    '{"0XS-0.5!",  8'h0c, 32'h96,   32'h96,  32'h0, 8'h31},
    '{"0XUP!",     8'h04, 32'h2390, 32'h9,   32'h3, 8'h32}
  };

  always #12.5 pclk = ~pclk;

  lgx_ext_cmd lgx_ext_cmd_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .continuous_mode(continuous_mode)
  );
  lgx_recorder lgx_recorder_i (
    .pclk(pclk), .slow(slow), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready)
  );
  //////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic summarize;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
  endtask
  // one command: answer chars, then registers it leaves behind
  task automatic run(input lgx_row_t w);
    logic [7:0] x [7];
    lgx_recorder_i.ans.delete();
    lgx_recorder_i.send(w.c);
    x = '{ea, 8'h30, 8'h30, 8'h31, w.n, 8'h0d, 8'h0a};
    // no answer expected: wait long enough for one to show
    if (w.n == 8'h00)
      repeat (40) @(posedge pclk);
    else
      for (int t = 0; t < 400 && lgx_recorder_i.ans.size() < 7; t++) @(posedge pclk);
    check(32'(lgx_recorder_i.ans.size()), (w.n == 8'h00) ? 32'h0 : 32'h7);
    for (int k = 0; k < 7 && k < lgx_recorder_i.ans.size(); k++)
      check(lgx_recorder_i.ans[k], x[k]);
    rdc(w.ra, w.rv);
    rdc(8'h20, w.d0);
    if (w.n == 8'h32)
      rdc(8'h24, w.d1);
    if (w.ra == 8'h04)
      check(continuous_mode, w.rv[0]);
  endtask
  //////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h30);
    rdc(8'h04, 32'h0200);
    rdc(8'h08, 32'h0);
    apb(1'b1, 8'h18, 32'h32);
    apb(1'b1, 8'h1c, 32'h64);
    // table, stalling recorder on every other row
    foreach (rows[i]) begin
      slow <= i[0];
      run(rows[i]);
    end
    // each units code 0 to 6 once
    for (int u = 0; u < 7; u++)
      run('{$sformatf("0XUP+%0d!", u), 8'h04, {24'h000023, u[3:0], 4'h0},
            32'(u), 32'h3, 8'h32});
    // density setup: level goes to density, offset kept
    apb(1'b1, 8'h00, 32'h130);
    run('{"0XS+1.02+3!", 8'h14, 32'h66, 32'h66, 32'h0, 8'h31});
    rdc(8'h0c, 32'h96);
    // new address answers, the old one is ignored
    apb(1'b1, 8'h00, 32'h35);
    ea = 8'h35;
    run('{"5XT+7!", 8'h08, 32'h7, 32'h7, 32'h0, 8'h31});
    run('{"0XT+8!", 8'h08, 32'h7, 32'h7, 32'h0, 8'h00});
    // read-only write ignored, unmapped refused
    apb(1'b1, 8'h08, 32'h5);
    check(e, 1'b0);
    rdc(8'h08, 32'h7);
    apb(1'b0, 8'h28, 32'h0);
    check(e, 1'b1);
    check(r, 32'h0);
    // clock enable low stretches a read
    fork
      apb(1'b0, 8'h08, 32'h0);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    check(r, 32'h7);
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h30);
    rdc(8'h08, 32'h0);
    summarize;
  end
endmodule // lgx_ext_cmd_tb
`default_nettype wire

// File: bench/lgx_recorder.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
// recorder side: sends command chars, collects answer chars
module lgx_recorder (
  input  wire logic       pclk,
  input  wire logic       slow,
  input  wire logic       rx_ready,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output var  logic       tx_ready
);
  logic [7:0] ans [$];  // answer chars, cleared by the bench
  // idle levels at time zero
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // one char per handshake; entered right after a rising edge
  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++) begin
      rx_valid <= 1'b1;
      rx_byte  <= s[k];
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    // released line shows the inverse, so a stale char never matches
    rx_byte  <= ~s[s.len()-1];
  endtask
  //////////////////////////////////////////////////////////////////////
  // capture answer; a slow recorder accepts every other cycle
  always @(posedge pclk) begin
    if (tx_valid && tx_ready)
      ans.push_back(tx_byte);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule // lgx_recorder
`default_nettype wire

// File: common/lgx_map.vh
//////////////////////////////////////////////////////////////////////
// Contract
// - level entry recomputes offset to match reading
// - density setup: level command sets density instead
// - missing line means line 1; missing level: keep
// - missing units: use currently selected level units
// - mode command reports, or sets when given
// - mode 0 on request, mode 1 continuous
// - level, mode, time answer address, ttt, 1
// - averaging time 0..900 seconds, optional, stored
// - units codes 0..6, code 9 user units
// - units command updates only present arguments
// - units command answers count 2, units, digits
// - data after level command gives resulting offset; in density setup it gives density
//////////////////////////////////////////////////////////////////////
`ifndef LGX_MAP_VH
`define LGX_MAP_VH

// register byte offsets
`define LGX_CTRL_OFS     8'h00
`define LGX_STAT_OFS     8'h04
`define LGX_AVG_OFS      8'h08
`define LGX_OFS1_OFS     8'h0c
`define LGX_OFS2_OFS     8'h10
`define LGX_DENS_OFS     8'h14
`define LGX_RDG1_OFS     8'h18
`define LGX_RDG2_OFS     8'h1c
`define LGX_DATA0_OFS    8'h20
`define LGX_DATA1_OFS    8'h24

// control fields
`define LGX_CTRL_ADDR_MSB 7
`define LGX_CTRL_DENS_BIT 8
// status fields
`define LGX_STAT_MODE_BIT 0
`define LGX_STAT_UNIT_LSB 4
`define LGX_STAT_DIG_LSB  8
`define LGX_STAT_CNT_LSB  12

// reset values
`define LGX_ADDR_RST     8'h30
`define LGX_UNITS_RST    4'h0
`define LGX_DIGITS_RST   4'h2
`define LGX_AVG_RST      10'h000

// argument limits
`define LGX_AVG_MAX      10'd900
`define LGX_UNITS_LAST   4'h6
`define LGX_UNITS_COMPAT 4'h9
`define LGX_DIGITS_MAX   4'h7

// completion time in seconds
`define LGX_DONE_SEC     1

// characters
`define LGX_CH_X     8'h58
`define LGX_CH_S     8'h53
`define LGX_CH_O     8'h4f
`define LGX_CH_M     8'h4d
`define LGX_CH_T     8'h54
`define LGX_CH_U     8'h55
`define LGX_CH_P     8'h50
`define LGX_CH_PLUS  8'h2b
`define LGX_CH_MINUS 8'h2d
`define LGX_CH_DOT   8'h2e
`define LGX_CH_BANG  8'h21
`define LGX_CH_ZERO  8'h30
`define LGX_CH_CR    8'h0d
`define LGX_CH_LF    8'h0a

`endif

// File: hdl/lgx_ext_cmd.v
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lgx_map.vh"
// extended command interpreter of the level gauge
module lgx_ext_cmd (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  output reg         rx_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_byte,
  input  wire        tx_ready,
  output reg         continuous_mode
);

  //////////////////////////////////////////////////////////////////
  // states and constants
  localparam [7:0] S_IDLE = 8'b0000_0001; // wait for address
  localparam [7:0] S_X    = 8'b0000_0010; // wait for X
  localparam [7:0] S_C1   = 8'b0000_0100; // first command letter
  localparam [7:0] S_C2   = 8'b0000_1000; // second command letter
  localparam [7:0] S_ARG  = 8'b0001_0000; // arguments up to bang
  localparam [7:0] S_SKIP = 8'b0010_0000; // silent until bang
  localparam [7:0] S_EXEC = 8'b0100_0000; // apply command
  localparam [7:0] S_RESP = 8'b1000_0000; // send answer

  localparam [3:0] C_LVL  = 4'b0001;      // set water level
  localparam [3:0] C_MODE = 4'b0010;      // operating mode
  localparam [3:0] C_AVG  = 4'b0100;      // averaging time
  localparam [3:0] C_UNIT = 4'b1000;      // level units

  localparam [31:0] T_HUN = `LGX_CH_ZERO + (`LGX_DONE_SEC / 100);
  localparam [31:0] T_TEN = `LGX_CH_ZERO + ((`LGX_DONE_SEC / 10) % 10);
  localparam [31:0] T_ONE = `LGX_CH_ZERO + (`LGX_DONE_SEC % 10);
  localparam [2:0] RESP_LAST = 3'd6;      // address ttt n cr lf

  //////////////////////////////////////////////////////////////////
  // helpers
  function is_digit;
    input [7:0] ch;
    begin
      is_digit = (ch >= 8'h30) && (ch <= 8'h39);
    end
  endfunction

  function is_sign;
    input [7:0] ch;
    begin
      is_sign = (ch == `LGX_CH_PLUS) || (ch == `LGX_CH_MINUS);
    end
  endfunction

  // answer character by position
  function [7:0] resp_char;
    input [2:0] idx;
    input [7:0] addr;
    input [1:0] cnt;
    begin
      case (idx)
        3'd0:    resp_char = addr;
        3'd1:    resp_char = T_HUN[7:0];
        3'd2:    resp_char = T_TEN[7:0];
        3'd3:    resp_char = T_ONE[7:0];
        3'd4:    resp_char = `LGX_CH_ZERO + {6'h00, cnt};
        3'd5:    resp_char = `LGX_CH_CR;
        default: resp_char = `LGX_CH_LF;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]  state_q;     // one-hot interpreter state
  reg  [3:0]  cmd_q;       // decoded command
  reg  [7:0]  want_q;      // expected second letter
  reg  [1:0]  line_q;      // selected line
  reg         arg_open_q;  // number being typed
  reg  [1:0]  arg_cnt_q;   // arguments closed so far
  reg  [31:0] arg_h_q [0:2]; // arguments in hundredths
  reg  [31:0] arg_i_q [0:2]; // integer parts
  reg  [2:0]  tx_idx_q;    // answer position

  reg  [7:0]  addr_q;      // own sensor address
  reg         dens_cfg_q;  // dual-line density setup
  reg         mode_q;      // 1 continuous
  reg  [3:0]  units_q;     // level units code
  reg  [3:0]  digits_q;    // digits right of point
  reg  [9:0]  avg_q;       // averaging seconds
  reg  [31:0] ofs1_q;      // line 1 offset
  reg  [31:0] ofs2_q;      // line 2 offset
  reg  [31:0] dens_q;      // density g/ml hundredths
  reg  [31:0] rdg1_q;      // line 1 reading, current units
  reg  [31:0] rdg2_q;      // line 2 reading, current units
  reg  [31:0] data0_q;     // first value for data request
  reg  [31:0] data1_q;     // second value for data request
  reg  [1:0]  dcnt_q;      // number of values

  wire        rx_take = rx_valid && rx_ready;
  wire        ch_sign = is_sign(rx_byte);
  wire        ch_dig  = is_digit(rx_byte);
  wire        ch_bang = (rx_byte == `LGX_CH_BANG);
  wire        ch_dot  = (rx_byte == `LGX_CH_DOT);
  wire [31:0] num_h;       // number being typed, hundredths
  wire [31:0] num_i;       // integer part of it

  //////////////////////////////////////////////////////////////////
  // number accumulator
  lgx_num_acc #(.W(32)) u_num (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (state_q == S_ARG && rx_take && ch_sign),
    .neg     (rx_byte == `LGX_CH_MINUS),
    .dig_v   (state_q == S_ARG && rx_take && ch_dig && arg_open_q),
    .dig     (rx_byte[3:0]),
    .dot     (state_q == S_ARG && rx_take && ch_dot && arg_open_q),
    .val_h   (num_h),
    .val_i   (num_i)
  );

  //////////////////////////////////////////////////////////////////
  // argument presence and values
  wire        a0 = (arg_cnt_q != 2'd0);
  wire        a1 = (arg_cnt_q >  2'd1);
  wire [31:0] lvl_rdg = (line_q == 2'd2) ? rdg2_q : rdg1_q;
  wire [31:0] lvl_ofs = (line_q == 2'd2) ? ofs2_q : ofs1_q;
  // offset shifts by the gap between entered and measured level
  wire [31:0] ofs_new = lvl_ofs + arg_h_q[0] - lvl_rdg;
  wire        avg_ok  = (arg_i_q[0][31:10] == 22'd0) &&
                        (arg_i_q[0][9:0] <= `LGX_AVG_MAX);
  wire        unit_ok = (arg_i_q[0][31:4] == 28'd0) &&
                        ((arg_i_q[0][3:0] <= `LGX_UNITS_LAST) ||
                         (arg_i_q[0][3:0] == `LGX_UNITS_COMPAT));
  wire        dig_ok  = (arg_i_q[1][31:4] == 28'd0) &&
                        (arg_i_q[1][3:0] <= `LGX_DIGITS_MAX);

  //////////////////////////////////////////////////////////////////
  // interpreter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= S_IDLE;
      cmd_q      <= 4'h0;
      want_q     <= 8'h00;
      line_q     <= 2'd1;
      arg_open_q <= 1'b0;
      arg_cnt_q  <= 2'd0;
      arg_h_q[0] <= 32'h0;
      arg_h_q[1] <= 32'h0;
      arg_h_q[2] <= 32'h0;
      arg_i_q[0] <= 32'h0;
      arg_i_q[1] <= 32'h0;
      arg_i_q[2] <= 32'h0;
      tx_idx_q   <= 3'd0;
      tx_valid   <= 1'b0;
      tx_byte    <= 8'h00;
      rx_ready   <= 1'b1;
      mode_q     <= 1'b0;
      units_q    <= `LGX_UNITS_RST;
      digits_q   <= `LGX_DIGITS_RST;
      avg_q      <= `LGX_AVG_RST;
      ofs1_q     <= 32'h0;
      ofs2_q     <= 32'h0;
      dens_q     <= 32'h0;
      data0_q    <= 32'h0;
      data1_q    <= 32'h0;
      dcnt_q     <= 2'd0;
      continuous_mode <= 1'b0;
    end else if (ce) begin
      continuous_mode <= mode_q;
      case (state_q)
        // foreign address keeps the line silent
        S_IDLE: if (rx_take && !ch_bang) begin
          if (rx_byte == addr_q)
            state_q <= S_X;
          else
            state_q <= S_SKIP;
        end
        S_X: if (rx_take) begin
          if (ch_bang)
            state_q <= S_IDLE;
          else if (rx_byte == `LGX_CH_X)
            state_q <= S_C1;
          else
            state_q <= S_SKIP;
        end
        // first letter, fresh argument state
        S_C1: if (rx_take) begin
          line_q     <= 2'd1;
          arg_open_q <= 1'b0;
          arg_cnt_q  <= 2'd0;
          if (ch_bang) begin
            state_q <= S_IDLE;
          end else if (rx_byte == `LGX_CH_S) begin
            cmd_q   <= C_LVL;
            state_q <= S_ARG;
          end else if (rx_byte == `LGX_CH_T) begin
            cmd_q   <= C_AVG;
            state_q <= S_ARG;
          end else if (rx_byte == `LGX_CH_O) begin
            cmd_q   <= C_MODE;
            want_q  <= `LGX_CH_M;
            state_q <= S_C2;
          end else if (rx_byte == `LGX_CH_U) begin
            cmd_q   <= C_UNIT;
            want_q  <= `LGX_CH_P;
            state_q <= S_C2;
          end else begin
            state_q <= S_SKIP;
          end
        end
        S_C2: if (rx_take) begin
          if (ch_bang)
            state_q <= S_IDLE;
          else if (rx_byte == want_q)
            state_q <= S_ARG;
          else
            state_q <= S_SKIP;
        end
        // arguments; a sign opens one and closes the previous
        S_ARG: if (rx_take) begin
          if (ch_sign || ch_bang) begin
            if (arg_open_q && arg_cnt_q != 2'd3) begin
              arg_h_q[arg_cnt_q] <= num_h;
              arg_i_q[arg_cnt_q] <= num_i;
              arg_cnt_q          <= arg_cnt_q + 2'd1;
            end
            arg_open_q <= ch_sign;
            if (ch_bang)
              state_q <= S_EXEC;
          end else if (ch_dig && !arg_open_q && arg_cnt_q == 2'd0
                       && cmd_q == C_LVL) begin
            // line selector digit, no sign before it
            line_q <= (rx_byte[3:0] == 4'd2) ? 2'd2 : 2'd1;
          end else if (!(ch_dig || ch_dot) || !arg_open_q) begin
            state_q <= S_SKIP;
          end
        end
        // apply and load data request values
        S_EXEC: begin
          dcnt_q  <= 2'd1;
          data1_q <= 32'h0;
          case (cmd_q)
            C_LVL: begin
              if (dens_cfg_q) begin
                // units argument never used for density
                if (a0)
                  dens_q <= arg_h_q[0];
                data0_q <= a0 ? arg_h_q[0] : dens_q;
              end else begin
                // level taken in current units, u never converts
                if (a0 && line_q == 2'd2)
                  ofs2_q <= ofs_new;
                else if (a0)
                  ofs1_q <= ofs_new;
                data0_q <= a0 ? ofs_new : lvl_ofs;
              end
            end
            C_MODE: begin
              if (a0 && arg_i_q[0][31:1] == 31'd0)
                mode_q <= arg_i_q[0][0];
              data0_q <= (a0 && arg_i_q[0][31:1] == 31'd0) ?
                         arg_i_q[0] : {31'd0, mode_q};
            end
            C_AVG: begin
              if (a0 && avg_ok)
                avg_q <= arg_i_q[0][9:0];
              data0_q <= (a0 && avg_ok) ?
                         arg_i_q[0] : {22'd0, avg_q};
            end
            C_UNIT: begin
              dcnt_q <= 2'd2;
              if (a0 && unit_ok)
                units_q <= arg_i_q[0][3:0];
              if (a1 && dig_ok)
                digits_q <= arg_i_q[1][3:0];
              data0_q <= (a0 && unit_ok) ?
                         arg_i_q[0] : {28'd0, units_q};
              data1_q <= (a1 && dig_ok) ?
                         arg_i_q[1] : {28'd0, digits_q};
            end
            default: data0_q <= 32'h0;
          endcase
          rx_ready <= 1'b0;
          tx_idx_q <= 3'd0;
          tx_valid <= 1'b1;
          tx_byte  <= addr_q;
          state_q  <= S_RESP;
        end
        // answer, one character per handshake
        S_RESP: if (tx_valid && tx_ready) begin
          if (tx_idx_q == RESP_LAST) begin
            tx_valid <= 1'b0;
            rx_ready <= 1'b1;
            state_q  <= S_IDLE;
          end else begin
            tx_idx_q <= tx_idx_q + 3'd1;
            tx_byte  <= resp_char(tx_idx_q + 3'd1, addr_q, dcnt_q);
          end
        end
        S_SKIP: if (rx_take && ch_bang)
          state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // apb slave, one wait state per access
  wire        apb_acc = psel && penable && pready;
  wire        hit_rw  = (paddr == `LGX_CTRL_OFS) ||
                        (paddr == `LGX_RDG1_OFS) ||
                        (paddr == `LGX_RDG2_OFS);
  wire        hit_ro  = (paddr == `LGX_STAT_OFS) ||
                        (paddr == `LGX_AVG_OFS)  ||
                        (paddr == `LGX_OFS1_OFS) ||
                        (paddr == `LGX_OFS2_OFS) ||
                        (paddr == `LGX_DENS_OFS) ||
                        (paddr == `LGX_DATA0_OFS) ||
                        (paddr == `LGX_DATA1_OFS);
  reg  [31:0] rd_mux;  // read value by address

  always @* begin
    rd_mux = 32'h0;
    case (paddr)
      `LGX_CTRL_OFS: begin
        rd_mux[`LGX_CTRL_ADDR_MSB:0] = addr_q;
        rd_mux[`LGX_CTRL_DENS_BIT]   = dens_cfg_q;
      end
      `LGX_STAT_OFS: begin
        rd_mux[`LGX_STAT_MODE_BIT]             = mode_q;
        rd_mux[`LGX_STAT_UNIT_LSB+3:`LGX_STAT_UNIT_LSB] = units_q;
        rd_mux[`LGX_STAT_DIG_LSB+3:`LGX_STAT_DIG_LSB]   = digits_q;
        rd_mux[`LGX_STAT_CNT_LSB+1:`LGX_STAT_CNT_LSB]   = dcnt_q;
      end
      `LGX_AVG_OFS:   rd_mux[9:0] = avg_q;
      `LGX_OFS1_OFS:  rd_mux = ofs1_q;
      `LGX_OFS2_OFS:  rd_mux = ofs2_q;
      `LGX_DENS_OFS:  rd_mux = dens_q;
      `LGX_RDG1_OFS:  rd_mux = rdg1_q;
      `LGX_RDG2_OFS:  rd_mux = rdg2_q;
      `LGX_DATA0_OFS: rd_mux = data0_q;
      `LGX_DATA1_OFS: rd_mux = data1_q;
      default:        rd_mux = 32'h0;
    endcase
  end

  // writes land only at the edge where pready is seen high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0;
      addr_q     <= `LGX_ADDR_RST;
      dens_cfg_q <= 1'b0;
      rdg1_q     <= 32'h0;
      rdg2_q     <= 32'h0;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !(hit_rw || hit_ro);
      if (psel && penable && !pready)
        prdata <= rd_mux;
      if (apb_acc && pwrite) begin
        case (paddr)
          `LGX_CTRL_OFS: begin
            addr_q     <= pwdata[`LGX_CTRL_ADDR_MSB:0];
            dens_cfg_q <= pwdata[`LGX_CTRL_DENS_BIT];
          end
          `LGX_RDG1_OFS: rdg1_q <= pwdata;
          `LGX_RDG2_OFS: rdg2_q <= pwdata;
          default:       rdg1_q <= rdg1_q;
        endcase
      end
    end
  end

endmodule // lgx_ext_cmd
`default_nettype wire

// File: hdl/lgx_num_acc.v
`timescale 1ns/1ps
`default_nettype none
// signed decimal accumulator, value kept in hundredths
module lgx_num_acc #(
  parameter W = 32
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire         start,
  input  wire         neg,
  input  wire         dig_v,
  input  wire [3:0]   dig,
  input  wire         dot,
  output wire [W-1:0] val_h,
  output wire [W-1:0] val_i
);
  reg [W-1:0] acc_q;   // digits up to the second fraction digit
  reg [W-1:0] int_q;   // integer part only
  reg [1:0]   frac_q;  // fraction digits kept
  reg         dot_q;   // point seen
  reg         neg_q;   // minus sign

  // digits past the second fraction digit are dropped, not rounded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= {W{1'b0}};
      int_q  <= {W{1'b0}};
      frac_q <= 2'd0;
      dot_q  <= 1'b0;
      neg_q  <= 1'b0;
    end else if (ce) begin
      if (start) begin
        acc_q  <= {W{1'b0}};
        int_q  <= {W{1'b0}};
        frac_q <= 2'd0;
        dot_q  <= 1'b0;
        neg_q  <= neg;
      end else if (dot) begin
        dot_q <= 1'b1;
      end else if (dig_v && frac_q != 2'd2) begin
        acc_q <= acc_q * 4'd10 + {{(W-4){1'b0}}, dig};
        if (dot_q)
          frac_q <= frac_q + 2'd1;
        else
          int_q <= int_q * 4'd10 + {{(W-4){1'b0}}, dig};
      end
    end
  end

  wire [W-1:0] mag_h = (frac_q == 2'd0) ? acc_q * 7'd100 :
                       (frac_q == 2'd1) ? acc_q * 4'd10 : acc_q;
  assign val_h = neg_q ? (~mag_h + 1'b1) : mag_h;
  assign val_i = neg_q ? (~int_q + 1'b1) : int_q;
endmodule // lgx_num_acc
`default_nettype wire
